// ---- hdl/csgp_cfg_pkg.sv ----
/*
 Constants for the chip-select and general purpose port configuration bank:
 register indices, reserved-bit masks, reset values and decode field layout.
 Assumes a single clock domain and a word-addressed Avalon-MM slave.
*/
package csgp_cfg_pkg;
   localparam int          ADDR_W        = 6;
   localparam logic [5:0]  IDX_CS_EN     = 6'h1a;
   localparam logic [5:0]  IDX_SEL0_LO   = 6'h1b;
   localparam logic [5:0]  IDX_SEL0_HI   = 6'h1c;
   localparam logic [5:0]  IDX_SEL1_LO   = 6'h1d;
   localparam logic [5:0]  IDX_SEL1_HI   = 6'h1e;
   localparam logic [5:0]  IDX_DEV_ID    = 6'h20;
   localparam logic [5:0]  IDX_GP_EN     = 6'h22;
   localparam logic [5:0]  IDX_GP_BASE   = 6'h23;
   localparam logic [5:0]  IDX_PA_DIR    = 6'h25;
   localparam logic [5:0]  IDX_PA_ISO    = 6'h26;
   localparam logic [5:0]  IDX_PB_DIR    = 6'h27;
   localparam logic [5:0]  IDX_PB_ISO    = 6'h28;
   // Reserved bits that always read as one
   localparam logic [7:0]  RSV_CS_EN     = 8'hf0;
   localparam logic [7:0]  RSV_SEL_LO    = 8'h03;
   localparam logic [7:0]  RSV_GP_EN     = 8'hfc;
   localparam logic [7:0]  RSV_PB        = 8'hf0;
   // Reset values of the writable bits
   localparam logic [7:0]  RST_ZERO      = 8'h00;
   // Field positions
   localparam int          CS_EN_A       = 0;
   localparam int          CS_HIZ_A      = 1;
   localparam int          CS_EN_B       = 2;
   localparam int          CS_HIZ_B      = 3;
   localparam int          RANGE_LSB     = 2;
   localparam int          BASE_LO_LSB   = 4;
   localparam int          GP_EN_A       = 0;
   localparam int          GP_EN_B       = 1;
   localparam int          IO_ADDR_W     = 16;
   localparam int          CS_BASE_W     = 12;
   localparam int          PB_LINES      = 4;
   localparam logic [1:0]  RANGE_16      = 2'h0;
   localparam logic [1:0]  RANGE_64      = 2'h1;
   localparam logic [1:0]  RANGE_256     = 2'h2;
   localparam logic [1:0]  RANGE_1K      = 2'h3;
   localparam logic [7:0]  DEV_ID_VALUE  = 8'h5a;  // Arbitrary value
endpackage

// ---- hdl/chip_select_gpio_config_regs.sv ----
/*
 Configuration bank for two address-decode chip selects, an identification
 byte and the setup of two general purpose ports, with its own decode logic.
 Assumes an Avalon-MM master on clk with word addressing; the I/O address
 bus and its valid strobe come from the host side, synchronous to clk.
*/
`timescale 1ns/1ps
// What this block does
// - Enable bit 0 turns select A on; bit 1 floats its pin.
// - Enable bit 2 turns select B on; bit 3 floats its pin.
// - Range field bits 3:2 pick 16, 64, 256 or 1K byte span.
// - Base is 12 bits: low nibble from bits 7:4, high byte from upper register.
// - Reserved configuration bits read as one whatever was written.
// - A read-only identification byte gives device type and revision.
// - Port enable bits 0 and 1 map or power down each general port.
// - Port A sits at twice the base select value, range 000h to 1feh.
// - Port B decodes at twice the base select value plus one.
// - Port A direction bits: zero input, one output.
// - Port A isolation bits: one puts the line in high impedance.
// - Port B has four direction bits; upper four reserved.
// - Port B isolation bits 3:0 float the matching line when one.
module chip_select_gpio_config_regs
   import csgp_cfg_pkg::*;
#(
   parameter logic [7:0] DEV_ID = DEV_ID_VALUE  // Arbitrary value
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic [ADDR_W-1:0]    address,
   input  wire logic                 read,
   input  wire logic                 write,
   input  wire logic [31:0]          writedata,
   input  wire logic [3:0]           byteenable,
   output logic      [31:0]          readdata,
   output logic                      waitrequest,
   output logic      [1:0]           response,
   input  wire logic [IO_ADDR_W-1:0] ioAddr,
   input  wire logic                 ioValid,
   output logic                      selectOutA,
   output logic                      selectOutAOe,
   output logic                      selectOutB,
   output logic                      selectOutBOe,
   output logic                      portAHit,
   output logic                      portBHit,
   output logic                      portAPowerDown,
   output logic                      portBPowerDown,
   output logic      [7:0]           portAOutEn,
   output logic      [PB_LINES-1:0]  portBOutEn,
   output logic      [7:0]           portADir,
   output logic      [PB_LINES-1:0]  portBDir
);

   logic [3:0]          csEn_q;
   logic [7:0]          sel0Lo_q;
   logic [7:0]          sel0Hi_q;
   logic [7:0]          sel1Lo_q;
   logic [7:0]          sel1Hi_q;
   logic [1:0]          gpEn_q;
   logic [7:0]          gpBase_q;
   logic [7:0]          paDir_q;
   logic [7:0]          paIso_q;
   logic [PB_LINES-1:0] pbDir_q;
   logic [PB_LINES-1:0] pbIso_q;
   logic                ack_q;
   logic [7:0]          rdByte_d;
   logic                mapped;
   logic                wrStb;
   logic [7:0]          wb;
   logic                selA_d;
   logic                selB_d;
   logic                hitA_d;
   logic                hitB_d;

   // One wait cycle, answer on the second edge
   assign waitrequest = (read | write) & ~ack_q;
   assign wrStb       = write & ack_q & byteenable[0];
   assign wb          = writedata[7:0];
   assign response    = mapped ? 2'h0 : 2'h2;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (read | write) & ~ack_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         csEn_q   <= RST_ZERO[3:0];
         sel0Lo_q <= RSV_SEL_LO;
         sel0Hi_q <= RST_ZERO;
         sel1Lo_q <= RSV_SEL_LO;
         sel1Hi_q <= RST_ZERO;
         gpEn_q   <= RST_ZERO[1:0];
         gpBase_q <= RST_ZERO;
         paDir_q  <= RST_ZERO;
         paIso_q  <= RST_ZERO;
         pbDir_q  <= RST_ZERO[PB_LINES-1:0];
         pbIso_q  <= RST_ZERO[PB_LINES-1:0];
      end else if (wrStb) begin
         case (address)
            IDX_CS_EN:   csEn_q   <= wb[3:0];
            IDX_SEL0_LO: sel0Lo_q <= wb | RSV_SEL_LO;
            IDX_SEL0_HI: sel0Hi_q <= wb;
            IDX_SEL1_LO: sel1Lo_q <= wb | RSV_SEL_LO;
            IDX_SEL1_HI: sel1Hi_q <= wb;
            IDX_GP_EN:   gpEn_q   <= wb[1:0];
            IDX_GP_BASE: gpBase_q <= wb;
            IDX_PA_DIR:  paDir_q  <= wb;
            IDX_PA_ISO:  paIso_q  <= wb;
            IDX_PB_DIR:  pbDir_q  <= wb[PB_LINES-1:0];
            IDX_PB_ISO:  pbIso_q  <= wb[PB_LINES-1:0];
            default: ;
         endcase
      end
   end

   // Read mux; reserved bits forced to one
   always_comb begin
      mapped   = 1'b1;
      rdByte_d = RST_ZERO;
      case (address)
         IDX_CS_EN:   rdByte_d = RSV_CS_EN | {4'h0, csEn_q};
         IDX_SEL0_LO: rdByte_d = sel0Lo_q | RSV_SEL_LO;
         IDX_SEL0_HI: rdByte_d = sel0Hi_q;
         IDX_SEL1_LO: rdByte_d = sel1Lo_q | RSV_SEL_LO;
         IDX_SEL1_HI: rdByte_d = sel1Hi_q;
         IDX_DEV_ID:  rdByte_d = DEV_ID;
         IDX_GP_EN:   rdByte_d = RSV_GP_EN | {6'h00, gpEn_q};
         IDX_GP_BASE: rdByte_d = gpBase_q;
         IDX_PA_DIR:  rdByte_d = paDir_q;
         IDX_PA_ISO:  rdByte_d = paIso_q;
         IDX_PB_DIR:  rdByte_d = RSV_PB | {4'h0, pbDir_q};
         IDX_PB_ISO:  rdByte_d = RSV_PB | {4'h0, pbIso_q};
         default:     mapped   = 1'b0;
      endcase
   end

   assign readdata = {24'h000000, rdByte_d};

   // Span match: compare only bits above the selected span
   function automatic logic spanMatch(input logic [IO_ADDR_W-1:0] a,
                                      input logic [7:0] lo, input logic [7:0] hi);
      logic [CS_BASE_W-1:0] base;
      logic [IO_ADDR_W-1:0] full;
      logic [IO_ADDR_W-1:0] mask;
      base = {hi, lo[7:BASE_LO_LSB]};
      full = {base, 4'h0};
      case (lo[RANGE_LSB+1:RANGE_LSB])
         RANGE_16:  mask = 16'hfff0;
         RANGE_64:  mask = 16'hffc0;
         RANGE_256: mask = 16'hff00;
         RANGE_1K:  mask = 16'hfc00;
         default:   mask = 16'hfff0;
      endcase
      spanMatch = ((a ^ full) & mask) == 16'h0000;
   endfunction

   always_comb begin
      selA_d = ioValid & csEn_q[CS_EN_A] & spanMatch(ioAddr, sel0Lo_q, sel0Hi_q);
      selB_d = ioValid & csEn_q[CS_EN_B] & spanMatch(ioAddr, sel1Lo_q, sel1Hi_q);
      hitA_d = ioValid & gpEn_q[GP_EN_A] & (ioAddr == {7'h00, gpBase_q, 1'b0});
      hitB_d = ioValid & gpEn_q[GP_EN_B] & (ioAddr == {7'h00, gpBase_q, 1'b1});
   end

   // Registered decode outputs; selects are active high
   always_ff @(posedge clk) begin
      if (!nrst) begin
         selectOutA <= 1'b0;
         selectOutB <= 1'b0;
         portAHit   <= 1'b0;
         portBHit   <= 1'b0;
      end else begin
         selectOutA <= selA_d;
         selectOutB <= selB_d;
         portAHit   <= hitA_d;
         portBHit   <= hitB_d;
      end
   end

   assign selectOutAOe   = ~csEn_q[CS_HIZ_A];
   assign selectOutBOe   = ~csEn_q[CS_HIZ_B];
   assign portAPowerDown = ~gpEn_q[GP_EN_A];
   assign portBPowerDown = ~gpEn_q[GP_EN_B];
   assign portADir       = paDir_q;
   assign portBDir       = pbDir_q;
   assign portAOutEn     = paDir_q & ~paIso_q;
   assign portBOutEn     = pbDir_q & ~pbIso_q;

   wait_one_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(read) |-> waitrequest ##1 !waitrequest) else $error("answer not after one wait");
   rsv_cs_a: assert property (@(posedge clk) disable iff (!nrst)
      (read && address == IDX_CS_EN) |-> readdata[7:4] == 4'hf) else $error("reserved bits not one");
   rsv_lo_a: assert property (@(posedge clk) disable iff (!nrst)
      (read && address == IDX_SEL1_LO) |-> readdata[1:0] == 2'h3) else $error("range reserved bits");
   id_fixed_a: assert property (@(posedge clk) disable iff (!nrst)
      (read && address == IDX_DEV_ID) |-> readdata[7:0] == DEV_ID) else $error("id byte wrong");
   sel_off_a: assert property (@(posedge clk) disable iff (!nrst)
      !csEn_q[CS_EN_A] |=> !selectOutA) else $error("select A active while off");
   selb_off_a: assert property (@(posedge clk) disable iff (!nrst)
      !csEn_q[CS_EN_B] |=> !selectOutB) else $error("select B active while off");
   hiz_a_a: assert property (@(posedge clk) disable iff (!nrst)
      (wrStb && address == IDX_CS_EN) |=> selectOutAOe == !$past(wb[1])) else $error("float ctrl");
   porta_hit_a: assert property (@(posedge clk) disable iff (!nrst)
      (ioValid && gpEn_q[0] && ioAddr == {7'h00, gpBase_q, 1'b0}) |=> portAHit)
      else $error("port A decode missed");
   portb_hit_a: assert property (@(posedge clk) disable iff (!nrst)
      portBHit |-> $past(ioAddr[0]) && $past(gpEn_q[1])) else $error("port B decode wrong");
   pd_a: assert property (@(posedge clk) disable iff (!nrst)
      portAPowerDown |=> !portAHit) else $error("powered-down port decoded");
   iso_a: assert property (@(posedge clk) disable iff (!nrst)
      (portAOutEn & paIso_q) == 8'h00 && (portBOutEn & pbIso_q) == 4'h0)
      else $error("isolated line driven");
   span_a: assert property (@(posedge clk) disable iff (!nrst)
      selectOutA |-> $past(ioAddr[15:10]) == sel0Hi_q[7:2] || $past(wrStb))
      else $error("select A outside 1K");

   wr_c: cover property (@(posedge clk) wrStb && address == IDX_SEL0_LO);
   sela_c: cover property (@(posedge clk) selectOutA);
   portb_c: cover property (@(posedge clk) portBHit);
   unmap_c: cover property (@(posedge clk) read && !waitrequest && !mapped);

endmodule

// ---- test/io_host_model.sv ----
/* Host side I/O address model: one-cycle address strobes on request.
 Assumes requests arrive on rising clk edges from the bench. */
`timescale 1ns/1ps
module io_host_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [15:0] addrIn,
   output logic             ioValid,
   output logic      [15:0] ioAddr
);
   initial begin
      ioValid = 1'b0;
      ioAddr = 16'h0;
   end
   // Idle bus alternates the last address with its complement
   always @(posedge clk) begin
      ioValid <= go;
      ioAddr <= go ? addrIn : ~ioAddr;
   end
endmodule

// ---- test/testbench.sv ----
/* Self-checking bench for the configuration bank and its decoders.
 Assumes the package constants and the io_host_model partner. */
`timescale 1ns/1ps
module testbench;
   import csgp_cfg_pkg::*;
   logic clk = 0, nrst = 0, read = 0, write = 0, go = 0, vQ = 0, waitrequest;
   logic selA, selAOe, selB, selBOe, hitA, hitB, pdA, pdB, ioValid;
   logic [5:0] address = 6'h0;
   logic [3:0] be = 4'h1, oeB, dirB;
   logic [31:0] writedata = 32'h0, readdata, seed = 32'h10560, r, q;
   logic [15:0] addrIn = 16'h0, ioAddr, base, a;
   logic [7:0] lo, hi, oeA, dirA;
   logic [1:0] response;
   logic [33:0] rdQ[$];
   logic [3:0] ioQ[$];
   int num_errors = 0, total_checks = 0;
   logic [5:0] idx [12] = '{IDX_CS_EN, IDX_SEL0_LO, IDX_SEL0_HI, IDX_SEL1_LO, IDX_SEL1_HI,
      IDX_DEV_ID, IDX_GP_EN, IDX_GP_BASE, IDX_PA_DIR, IDX_PA_ISO, IDX_PB_DIR, IDX_PB_ISO};
   logic [7:0] rst [12] = '{8'hf0, 8'h03, 8'h00, 8'h03, 8'h00, DEV_ID_VALUE, 8'hfc, 8'h00,
      8'h00, 8'h00, 8'hf0, 8'hf0};
   logic [7:0] rsv [12] = '{RSV_CS_EN, RSV_SEL_LO, 8'h0, RSV_SEL_LO, 8'h0, 8'h0, RSV_GP_EN,
      8'h0, 8'h0, 8'h0, RSV_PB, RSV_PB};

   chip_select_gpio_config_regs dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
      .waitrequest(waitrequest), .response(response), .ioAddr(ioAddr), .ioValid(ioValid),
      .selectOutA(selA), .selectOutAOe(selAOe), .selectOutB(selB), .selectOutBOe(selBOe),
      .portAHit(hitA), .portBHit(hitB), .portAPowerDown(pdA), .portBPowerDown(pdB),
      .portAOutEn(oeA), .portBOutEn(oeB), .portADir(dirA), .portBDir(dirB));
   io_host_model host (.clk(clk), .go(go), .addrIn(addrIn), .ioValid(ioValid), .ioAddr(ioAddr));

   always #20 clk = ~clk;

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Select span match above the range size
   function logic m(logic [15:0] x, logic [7:0] l, logic [7:0] h);
      return ((x ^ {h, l[7:4], 4'h0}) >> (4 + 2 * l[3:2])) == 16'h0;
   endfunction
   task chk(string n, logic [33:0] e, logic [33:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task bus(logic wr, logic [5:0] ad, logic [7:0] d, logic [33:0] e);
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= ad;
      writedata <= {24'h0, d};
      if (!wr) rdQ.push_back(e);
      do @(posedge clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
      @(negedge clk);
   endtask
   task wr(logic [5:0] ad, logic [7:0] d);
      bus(1'b1, ad, d, 34'h0);
   endtask
   task rd(logic [5:0] ad, logic [7:0] e);
      bus(1'b0, ad, 8'h0, {26'h0, e});
   endtask
   task io(logic [15:0] x, logic [3:0] e);
      @(posedge clk);
      go <= 1'b1;
      addrIn <= x;
      ioQ.push_back(e);
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // Result watcher
   always @(posedge clk) begin
      if (read === 1'b1 && waitrequest === 1'b0) chk("read", rdQ.pop_front(), {response, readdata});
      if (vQ) chk("decode", ioQ.pop_front(), {selA, selB, hitA, hitB});
      vQ <= ioValid;
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 12; i++) rd(idx[i], rst[i]);
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         wr(idx[i], r[7:0]);
         rd(idx[i], (i == 5) ? DEV_ID_VALUE : r[7:0] | rsv[i]);
      end
      wr(6'h3f, 8'hff);
      bus(1'b0, 6'h3f, 8'h0, {2'b10, 32'h0});
      wr(IDX_PA_DIR, 8'h00);
      be <= 4'h0;
      wr(IDX_PA_DIR, 8'hff);
      be <= 4'h1;
      rd(IDX_PA_DIR, 8'h00);
      r = rnd();
      q = rnd();
      wr(IDX_PA_DIR, r[7:0]);
      wr(IDX_PA_ISO, q[7:0]);
      wr(IDX_PB_DIR, r[15:8]);
      wr(IDX_PB_ISO, q[15:8]);
      chk("dirA", r[7:0], dirA);
      chk("oeA", r[7:0] & ~q[7:0], oeA);
      chk("dirB", r[11:8], dirB);
      chk("oeB", r[11:8] & ~q[11:8], oeB);
      wr(IDX_GP_EN, 8'h00);
      wr(IDX_CS_EN, 8'h05);
      chk("oe", 2'b11, {selAOe, selBOe});
      for (int g = 0; g < 4; g++) begin
         r = rnd();
         lo = {r[7:4], 2'(g), 2'b00};
         hi = r[15:8];
         wr(IDX_SEL0_LO, lo);
         wr(IDX_SEL0_HI, hi);
         wr(IDX_SEL1_LO, lo);
         wr(IDX_SEL1_HI, hi ^ 8'h80);
         base = {hi, lo[7:4], 4'h0};
         for (int k = 0; k < 3; k++) begin
            a = base + ((k > 0) ? (16'h10 << (2 * g)) - {15'h0, k == 1} : 16'h0);
            io(a, {m(a, lo, hi), m(a, lo, hi ^ 8'h80), 2'b00});
         end
      end
      wr(IDX_CS_EN, 8'h0a);
      chk("oe", 2'b00, {selAOe, selBOe});
      io(base, 4'h0);
      for (int j = 0; j < 2; j++) begin
         r = (j == 0) ? rnd() : 32'hff;
         a = {7'h0, r[7:0], 1'b0};
         wr(IDX_GP_BASE, r[7:0]);
         wr(IDX_GP_EN, 8'h03);
         chk("pd", 2'b00, {pdA, pdB});
         io(a, 4'b0010);
         io(a + 16'h1, 4'b0001);
         io(a + 16'h2, 4'b0000);
         wr(IDX_GP_EN, 8'h02);
         chk("pd", 2'b10, {pdA, pdB});
         io(a, 4'b0000);
      end
      wrap_up();
   end
endmodule
